// ==== src/watch_pkg.sv ====
// Register map, field positions and timing constants of the watchdog channel
package watch_pkg;
    localparam int          CLOCK_PERIOD_NS   = 50;
    localparam int          RESET_OUT_NS      = 1000;
    localparam int          RESET_OUT_CYCLES  = (RESET_OUT_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int          RESET_CNT_W       = 6;

    localparam logic [3:0]  ADDR_COUNTER      = 4'h0;
    localparam logic [3:0]  ADDR_CTRL_STATUS  = 4'h4;
    localparam logic [3:0]  ADDR_IRQ_STATUS   = 4'h8;
    localparam logic [3:0]  ADDR_IRQ_MASK     = 4'hc;

    localparam int          BIT_OVERFLOW      = 7;
    localparam int          BIT_MODE          = 6;
    localparam int          BIT_RUN           = 5;
    localparam int          BIT_RESERVED      = 4;
    localparam int          BIT_ACTION        = 3;
    localparam int          CKS_LSB           = 0;
    localparam int          CKS_W             = 3;

    localparam logic [7:0]  COUNTER_RESET     = 8'h00;
    localparam logic [7:0]  CTRL_RESET        = 8'h00;
    localparam logic [7:0]  COUNTER_MAX       = 8'hff;

    localparam int          EV_W              = 3;
    localparam int          EV_OVERFLOW       = 0;
    localparam int          EV_NMI            = 1;
    localparam int          EV_RESET          = 2;
    localparam logic [2:0]  EV_RESET_VALUE    = 3'h0;

    localparam int          PRESCALE_W        = 17;

    localparam logic [1:0]  RESP_OKAY         = 2'h0;
    localparam logic [1:0]  RESP_SLVERR       = 2'h2;
endpackage

// ==== src/watch_prescaler.sv ====
// System clock divider, held at zero while stopped, giving the selected counter tick
`timescale 1ns/1ns
`default_nettype none
module watch_prescaler
(
    input  wire logic                                clock,
    input  wire logic                                rst,
    input  wire logic                                hold,
    input  wire logic [watch_pkg::CKS_W-1:0]         clock_select,
    output logic                                     tick
);
    logic [watch_pkg::PRESCALE_W-1:0] divider;

    // Mask of low divider bits whose all-ones state ends one divided period
    function automatic logic [watch_pkg::PRESCALE_W-1:0] tap_mask(input logic [watch_pkg::CKS_W-1:0] sel);
        case (sel)
            3'h0:    tap_mask = 17'h00001;
            3'h1:    tap_mask = 17'h0003f;
            3'h2:    tap_mask = 17'h0007f;
            3'h3:    tap_mask = 17'h001ff;
            3'h4:    tap_mask = 17'h007ff;
            3'h5:    tap_mask = 17'h01fff;
            3'h6:    tap_mask = 17'h07fff;
            default: tap_mask = 17'h1ffff;
        endcase
    endfunction

    // Held while stopped so the first period after start is a full one
    always_ff @(posedge clock)
    begin
        if (rst || hold)
            divider <= '0;
        else
            divider <= divider + 17'h00001;
    end

    always_ff @(posedge clock)
    begin
        if (rst || hold)
            tick <= 1'b0;
        else
            tick <= ((divider & tap_mask(clock_select)) == tap_mask(clock_select));
    end
endmodule
`default_nettype wire

// ==== src/watch_timer.sv ====
// Watchdog / interval timer channel with AXI4-Lite register access
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - Counter is eight bits, counts upward, readable and writable.
// - Run bit at one makes the counter step on every prescaler tick.
// - Run bit at zero stops the counter and holds it at zero.
// - Wrap from ff to 00 sets overflow flag, control bit 7.
// - Internal reset from watchdog overflow clears the overflow flag itself.
// - Flag cleared by read-while-set then zero write; writing one ignored.
// - Writing zero to the run bit also clears the overflow flag.
// - Control bit 6 picks mode: zero interval, one watchdog.
// - Control bit 3 picks watchdog action: zero interrupt, one internal reset.
// - Interval mode raises the interval interrupt on every overflow.
// - Watchdog mode overflow gives internal reset or non-maskable interrupt.
// - In watchdog mode with reset action selected, overflow drives the reset output pin low.
// - Counter and control writes need the protected path; plain writes ignored.
module watch_timer
(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        write_key_ok,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             interval_overflow_irq,
    output logic             nmi_req,
    output logic             internal_reset_req,
    output logic             overflow_reset_out_n,
    output logic             irq
);
    // Local copy keeps the width cast on the reset pin counter short
    localparam int RESET_CNT_W = watch_pkg::RESET_CNT_W;

    logic [7:0]                        watch_counter;
    logic                              overflow_flag;
    logic                              timer_mode_select;
    logic                              run_enable;
    logic                              overflow_action;
    logic [watch_pkg::CKS_W-1:0]       clock_select;
    logic                              armed;
    logic [watch_pkg::EV_W-1:0]        irq_status;
    logic [watch_pkg::EV_W-1:0]        irq_mask;
    logic [watch_pkg::RESET_CNT_W-1:0] reset_out_count;

    logic [3:0]                        aw_addr;
    logic                              aw_held;
    logic [7:0]                        w_data;
    logic                              w_lane0;
    logic                              w_held;
    logic                              tick;

    logic                              do_write;
    logic                              do_read;
    logic [3:0]                        ar_addr;
    logic                              wr_counter;
    logic                              wr_ctrl;
    logic                              overflow;
    logic                              wd_reset;
    logic                              wd_nmi;
    logic [watch_pkg::EV_W-1:0]        events;

    // Addresses are word aligned; upper bits must be zero and the low nibble selects the register
    function automatic logic mapped(input logic [31:0] addr);
        mapped = (addr[31:4] == 28'h0000000) && (addr[1:0] == 2'h0);
    endfunction

    assign do_write   = aw_held && w_held && !s_axi_bvalid;
    assign do_read    = s_axi_arvalid && s_axi_arready;
    assign ar_addr    = s_axi_araddr[3:0];

    // Plain writes still get OKAY but leave protected registers untouched
    assign wr_counter = do_write && w_lane0 && write_key_ok && (aw_addr == watch_pkg::ADDR_COUNTER);
    assign wr_ctrl    = do_write && w_lane0 && write_key_ok && (aw_addr == watch_pkg::ADDR_CTRL_STATUS);

    // A counter write in the tick cycle wins and swallows the step
    assign overflow   = run_enable && tick && !wr_counter && (watch_counter == watch_pkg::COUNTER_MAX);
    assign wd_reset   = overflow && timer_mode_select && overflow_action;
    assign wd_nmi     = overflow && timer_mode_select && !overflow_action;

    assign events[watch_pkg::EV_OVERFLOW] = overflow;
    assign events[watch_pkg::EV_NMI]      = wd_nmi;
    assign events[watch_pkg::EV_RESET]    = wd_reset;

    watch_prescaler u_prescaler
    (
        .clock        (clock),
        .rst          (rst),
        .hold         (!run_enable),
        .clock_select (clock_select),
        .tick         (tick)
    );

    // Write address channel
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            aw_held       <= 1'b0;
            aw_addr       <= 4'h0;
            s_axi_awready <= 1'b1;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held       <= 1'b1;
            aw_addr       <= mapped(s_axi_awaddr) ? s_axi_awaddr[3:0] : 4'h1;
            s_axi_awready <= 1'b0;
        end
        else if (s_axi_bvalid && s_axi_bready)
        begin
            aw_held       <= 1'b0;
            s_axi_awready <= 1'b1;
        end
    end

    // Write data channel; only the low byte lane carries register data
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            w_held       <= 1'b0;
            w_data       <= 8'h00;
            w_lane0      <= 1'b0;
            s_axi_wready <= 1'b1;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_held       <= 1'b1;
            w_data       <= s_axi_wdata[7:0];
            w_lane0      <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
        end
        else if (s_axi_bvalid && s_axi_bready)
        begin
            w_held       <= 1'b0;
            s_axi_wready <= 1'b1;
        end
    end

    // Write response once both halves are in
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= watch_pkg::RESP_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            case (aw_addr)
                watch_pkg::ADDR_COUNTER,
                watch_pkg::ADDR_CTRL_STATUS,
                watch_pkg::ADDR_IRQ_STATUS,
                watch_pkg::ADDR_IRQ_MASK: s_axi_bresp <= watch_pkg::RESP_OKAY;
                default:                  s_axi_bresp <= watch_pkg::RESP_SLVERR;
            endcase
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // Read channel
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= watch_pkg::RESP_OKAY;
        end
        else if (do_read)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= watch_pkg::RESP_OKAY;
            s_axi_rdata   <= 32'h00000000;
            if (!mapped(s_axi_araddr))
                s_axi_rresp <= watch_pkg::RESP_SLVERR;
            else
                case (ar_addr)
                    watch_pkg::ADDR_COUNTER:     s_axi_rdata[7:0] <= watch_counter;
                    watch_pkg::ADDR_CTRL_STATUS: s_axi_rdata[7:0] <= {overflow_flag, timer_mode_select, run_enable,
                                                                     1'b0, overflow_action, clock_select};
                    watch_pkg::ADDR_IRQ_STATUS:  s_axi_rdata[watch_pkg::EV_W-1:0] <= irq_status;
                    watch_pkg::ADDR_IRQ_MASK:    s_axi_rdata[watch_pkg::EV_W-1:0] <= irq_mask;
                    default:                     s_axi_rresp <= watch_pkg::RESP_SLVERR;
                endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Watch counter
    always_ff @(posedge clock)
    begin
        if (rst)
            watch_counter <= watch_pkg::COUNTER_RESET;
        else if (!run_enable || (wr_ctrl && !w_data[watch_pkg::BIT_RUN]))
            watch_counter <= watch_pkg::COUNTER_RESET;
        else if (wr_counter)
            watch_counter <= w_data;
        else if (tick)
            watch_counter <= watch_counter + 8'h01;
    end

    // Control fields; reserved bit is never stored and reads zero
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            timer_mode_select <= watch_pkg::CTRL_RESET[watch_pkg::BIT_MODE];
            run_enable        <= watch_pkg::CTRL_RESET[watch_pkg::BIT_RUN];
            overflow_action   <= watch_pkg::CTRL_RESET[watch_pkg::BIT_ACTION];
            clock_select      <= watch_pkg::CTRL_RESET[watch_pkg::CKS_W-1:0];
        end
        else if (wr_ctrl)
        begin
            timer_mode_select <= w_data[watch_pkg::BIT_MODE];
            run_enable        <= w_data[watch_pkg::BIT_RUN];
            overflow_action   <= w_data[watch_pkg::BIT_ACTION];
            clock_select      <= w_data[watch_pkg::CKS_LSB +: watch_pkg::CKS_W];
        end
    end

    // Arming by a read of control while the flag is set
    // Any keyed control write disarms, so a stale read cannot clear a later overflow
    always_ff @(posedge clock)
    begin
        if (rst)
            armed <= 1'b0;
        else if (do_read && mapped(s_axi_araddr) && ar_addr == watch_pkg::ADDR_CTRL_STATUS && overflow_flag)
            armed <= 1'b1;
        else if (wr_ctrl || !overflow_flag)
            armed <= 1'b0;
    end

    // Overflow flag: a new overflow beats any clear in the same cycle
    always_ff @(posedge clock)
    begin
        if (rst)
            overflow_flag <= watch_pkg::CTRL_RESET[watch_pkg::BIT_OVERFLOW];
        else if (overflow)
            overflow_flag <= 1'b1;
        else if (internal_reset_req)
            overflow_flag <= 1'b0;
        else if (wr_ctrl && !w_data[watch_pkg::BIT_RUN])
            overflow_flag <= 1'b0;
        else if (wr_ctrl && armed && !w_data[watch_pkg::BIT_OVERFLOW])
            overflow_flag <= 1'b0;
    end

    // Overflow action pulses
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            interval_overflow_irq <= 1'b0;
            nmi_req               <= 1'b0;
            internal_reset_req    <= 1'b0;
        end
        else
        begin
            interval_overflow_irq <= overflow && !timer_mode_select;
            nmi_req               <= wd_nmi;
            internal_reset_req    <= wd_reset;
        end
    end

    // External reset pin held low for a fixed width after a reset overflow
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            reset_out_count      <= '0;
            overflow_reset_out_n <= 1'b1;
        end
        else if (wd_reset)
        begin
            reset_out_count      <= RESET_CNT_W'(watch_pkg::RESET_OUT_CYCLES - 1);
            overflow_reset_out_n <= 1'b0;
        end
        else if (reset_out_count != '0)
            reset_out_count      <= reset_out_count - 1'b1;
        else
            overflow_reset_out_n <= 1'b1;
    end

    // Sticky event status, write one to clear, set wins
    always_ff @(posedge clock)
    begin
        if (rst)
            irq_status <= watch_pkg::EV_RESET_VALUE;
        else if (do_write && w_lane0 && aw_addr == watch_pkg::ADDR_IRQ_STATUS)
            irq_status <= (irq_status & ~w_data[watch_pkg::EV_W-1:0]) | events;
        else
            irq_status <= irq_status | events;
    end

    // Mask shares the status layout; a one lets that event reach irq
    always_ff @(posedge clock)
    begin
        if (rst)
            irq_mask <= watch_pkg::EV_RESET_VALUE;
        else if (do_write && w_lane0 && aw_addr == watch_pkg::ADDR_IRQ_MASK)
            irq_mask <= w_data[watch_pkg::EV_W-1:0];
    end

    // One cycle behind the status bits
    always_ff @(posedge clock)
    begin
        if (rst)
            irq <= 1'b0;
        else
            irq <= |(irq_status & irq_mask);
    end
endmodule
`default_nettype wire

// ==== tb/watch_irq_sink.sv ====
// Interrupt controller stand-in that counts the channel's event requests
`timescale 1ns/1ns
`default_nettype none
module watch_irq_sink
(
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic interval_overflow_irq,
    input  wire logic nmi_req,
    input  wire logic internal_reset_req,
    output var  int   n_interval,
    output var  int   n_nmi,
    output var  int   n_reset
);
    // Requests are single-cycle pulses, so each high sample is one event
    always_ff @(posedge clock)
    begin
        n_interval <= rst ? 0 : n_interval + int'(interval_overflow_irq === 1'b1);
        n_nmi      <= rst ? 0 : n_nmi + int'(nmi_req === 1'b1);
        n_reset    <= rst ? 0 : n_reset + int'(internal_reset_req === 1'b1);
    end
endmodule
`default_nettype wire

// ==== tb/watch_timer_asserts.sv ====
// Concurrent checks on the watchdog channel ports
`timescale 1ns/1ns
`default_nettype none
module watch_timer_asserts
(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic        interval_overflow_irq,
    input  wire logic        nmi_req,
    input  wire logic        internal_reset_req,
    input  wire logic        overflow_reset_out_n
);
    int low_cnt;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // Length of the current low stretch of the reset pin
    always_ff @(posedge clock)
        low_cnt <= (rst || overflow_reset_out_n) ? 0 : low_cnt + 1;
    AST_IVL_PULSE: assert property (interval_overflow_irq |=> !interval_overflow_irq [*8])
        else $error("interval request not a single pulse");
    AST_NMI_PULSE: assert property (nmi_req |=> !nmi_req [*8])
        else $error("nmi request not a single pulse");
    AST_ONE_EVENT: assert property ($onehot0({interval_overflow_irq, nmi_req, internal_reset_req}))
        else $error("two overflow actions at once");
    AST_OVERFLOW_RESET_OUT_N_START: assert property ($rose(internal_reset_req) |-> ##[0:1] !overflow_reset_out_n)
        else $error("reset pin not driven low");
    AST_OVERFLOW_RESET_OUT_N_WIDTH: assert property ($rose(overflow_reset_out_n) && !$past(rst)
        |-> low_cnt == watch_pkg::RESET_OUT_CYCLES)
        else $error("reset pin low time wrong");
    AST_OVERFLOW_RESET_OUT_N_CAUSE: assert property ($fell(overflow_reset_out_n) |-> internal_reset_req || $past(internal_reset_req))
        else $error("reset pin low without reset request");
    AST_RDATA_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    AST_BRESP_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");
    cover property (interval_overflow_irq);
    cover property (nmi_req);
    cover property ($rose(overflow_reset_out_n));
endmodule
bind watch_timer watch_timer_asserts u_asserts (.clock, .rst, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .interval_overflow_irq, .nmi_req, .internal_reset_req,
    .overflow_reset_out_n);
`default_nettype wire

// ==== tb/watch_timer_tb.sv ====
// Register-level testbench for the watchdog channel
`timescale 1ns/1ns
`default_nettype none
module watch_timer_tb;
    logic        clock = 1'b0, rst = 1'b1, write_key_ok = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic        interval_overflow_irq, nmi_req, internal_reset_req, overflow_reset_out_n, irq;
    wire  [2:0]  ev = {internal_reset_req, nmi_req, interval_overflow_irq};
    int          miscompares = 0, n_tests = 0, n_interval, n_nmi, n_reset, cyc;
    int          divs [8] = '{2, 64, 128, 512, 2048, 8192, 32768, 131072};

    watch_timer u_dut (.clock, .rst, .write_key_ok, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .interval_overflow_irq, .nmi_req, .internal_reset_req, .overflow_reset_out_n, .irq);
    watch_irq_sink u_sink (.clock, .rst, .interval_overflow_irq, .nmi_req, .internal_reset_req,
        .n_interval, .n_nmi, .n_reset);

    initial
        forever #25 clock = ~clock;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        if (miscompares == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic k);
        logic a_ok;
        logic w_ok;
        a_ok = 1'b0;
        w_ok = 1'b0;
        s_axi_awaddr  <= {24'h0, a};
        s_axi_wdata   <= {24'h0, v};
        write_key_ok  <= k;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        // Each channel released at its own handshake edge
        while (!(a_ok && w_ok))
        begin
            @(posedge clock);
            a_ok = a_ok | (s_axi_awready === 1'b1);
            w_ok = w_ok | (s_axi_wready === 1'b1);
            s_axi_awvalid <= !a_ok;
            s_axi_wvalid  <= !w_ok;
        end
        // Response ready held back so the slave must keep its answer standing
        repeat (2) @(posedge clock);
        s_axi_bready <= 1'b1;
        do @(posedge clock); while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        s_axi_araddr  <= {24'h0, a};
        s_axi_arvalid <= 1'b1;
        do @(posedge clock); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        // Ready raised a cycle late so the read data must stand
        @(posedge clock);
        s_axi_rready  <= 1'b1;
        do @(posedge clock); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        chk(d, exp);
    endtask

    // Counting starts after the launching call, so limits carry some slack
    task automatic wait_ev(input int which, input int limit);
        cyc = 0;
        do
        begin
            @(posedge clock);
            cyc++;
        end
        while (ev[which] !== 1'b1 && cyc < limit);
    endtask

    initial
    begin
        #(30000 * 50);
        miscompares++;
        tally_and_finish();
    end

    initial
    begin
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        rchk(8'h00, 32'h0);
        rchk(8'h04, 32'h0);
        rd(8'h10);
        chk(resp, watch_pkg::RESP_SLVERR);
        wr(8'h10, 8'h00, 1'b1);
        chk(resp, watch_pkg::RESP_SLVERR);
        wr(8'h04, 8'h20, 1'b1);
        wr(8'h00, 8'hf0, 1'b0);
        chk(resp, watch_pkg::RESP_OKAY);
        rd(8'h00);
        chk(d[7:4], 4'h0);
        wr(8'h00, 8'hf0, 1'b1);
        rd(8'h00);
        chk(d[7:2], 6'h3c);
        wait_ev(0, 100);
        chk(ev[0], 1'b1);
        rchk(8'h04, 32'ha0);
        rchk(8'h04, 32'ha0);
        wr(8'h04, 8'ha0, 1'b1);
        wr(8'h04, 8'h20, 1'b1);
        rchk(8'h04, 32'ha0);
        wr(8'h04, 8'h20, 1'b1);
        rchk(8'h04, 32'h20);
        rchk(8'h08, 32'h1);
        wr(8'h0c, 8'h01, 1'b0);
        @(posedge clock);
        chk(irq, 1'b1);
        wr(8'h08, 8'h01, 1'b0);
        @(posedge clock);
        chk(irq, 1'b0);
        wr(8'h04, 8'h60, 1'b1);
        wr(8'h00, 8'hf0, 1'b1);
        wait_ev(1, 100);
        chk(ev[1], 1'b1);
        rd(8'h08);
        chk(d[1], 1'b1);
        wr(8'h04, 8'h00, 1'b1);
        rchk(8'h04, 32'h0);
        rchk(8'h00, 32'h0);
        wr(8'h04, 8'h68, 1'b1);
        wr(8'h00, 8'hf0, 1'b1);
        wait_ev(2, 100);
        chk(ev[2], 1'b1);
        @(posedge clock);
        chk(overflow_reset_out_n, 1'b0);
        rchk(8'h04, 32'h68);
        chk({n_interval[1:0], n_nmi[1:0], n_reset[1:0]}, 6'h15);
        wr(8'h04, 8'h00, 1'b1);
        // Divider held at zero while stopped, so the first tick is one period after start
        for (int c = 1; c < 6; c++)
        begin
            wr(8'h04, 8'h20 | c[7:0], 1'b1);
            wr(8'h00, 8'hff, 1'b1);
            wait_ev(0, divs[c] + 20);
            chk(cyc > divs[c] - 20 && cyc < divs[c] + 8, 1'b1);
            wr(8'h04, 8'h00, 1'b1);
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
